// *** core/qec_pkg.sv ***
// package of constants and types for the quadrature encoder control block
package qec_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0; // control register
  localparam logic [3:0] ADDR_POS = 4'h1; // position / timer count
  localparam logic [3:0] ADDR_MAX = 4'h2; // maximum count value
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] POS_RESET = 16'h0000;
  localparam logic [15:0] MAX_RESET = 16'hFFFF;
  localparam logic [15:0] CTRL_WMASK = 16'h27FF; // bits 15,14,12,11 not plain writable

  // ****************************************
  // control field positions
  // ****************************************
  localparam int BIT_CNT_ERR = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_INDEX = 12;
  localparam int BIT_DIR = 11;
  localparam int BIT_MODE_HI = 10;
  localparam int BIT_MODE_LO = 8;
  localparam int BIT_SWAP = 7;
  localparam int BIT_DIR_OE = 6;
  localparam int BIT_GATE = 5;
  localparam int BIT_DIR_SRC = 0;

  // ****************************************
  // operating mode encodings
  // ****************************************
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_TIMER = 3'h1;
  localparam logic [2:0] MODE_UNUSED2 = 3'h2;
  localparam logic [2:0] MODE_UNUSED3 = 3'h3;
  localparam logic [2:0] MODE_X2_IDX = 3'h4;
  localparam logic [2:0] MODE_X2_MAX = 3'h5;
  localparam logic [2:0] MODE_X4_IDX = 3'h6;
  localparam logic [2:0] MODE_X4_MAX = 3'h7;

  // decoded mode carried to the counter
  typedef struct packed {
    logic enc_en;   // quadrature decoding active
    logic x4;       // count on both phases
    logic idx_rst;  // index pulse resets counter
    logic max_rst;  // match with maximum resets counter
    logic timer_en; // general timer
  } qec_mode_s;

endpackage

// *** core/qec_quad_decoder.sv ***
// quadrature phase edge decoder producing count pulses and direction
`timescale 1ns/1ps
module qec_quad_decoder (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_x4,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  output logic o_count,
  output logic o_up
);
  logic a_q;
  logic b_q;
  logic a_edge;
  logic b_edge;

  // previous phase levels
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= i_phase_a;
      b_q <= i_phase_b;
    end
  end

  // x2 counts phase a edges only, x4 counts both phases
  assign a_edge = a_q ^ i_phase_a;
  assign b_edge = b_q ^ i_phase_b;
  assign o_count = i_run & (a_edge | (i_x4 & b_edge));
  // a leading b counts up
  assign o_up = a_edge ? (i_phase_a ^ i_phase_b) : ~(i_phase_a ^ i_phase_b);
endmodule // qec_quad_decoder

// *** core/qec_core.sv ***
// quadrature encoder control: register file, mode decode and position counter
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module qec_core (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic i_index,
  input wire logic i_idle,
  input wire logic i_timer_tick,
  input wire logic i_timer_gate,
  output logic o_dir,
  output logic o_dir_oe
);

  // ****************************************
  // mode decode
  // ****************************************
  function automatic qec_pkg::qec_mode_s mode_decode(input logic [2:0] m);
    qec_pkg::qec_mode_s r;
    r = '0;
    unique case (m)
      qec_pkg::MODE_X4_MAX: begin
        r.enc_en = 1'b1;
        r.x4 = 1'b1;
        r.max_rst = 1'b1;
      end
      qec_pkg::MODE_X4_IDX: begin
        r.enc_en = 1'b1;
        r.x4 = 1'b1;
        r.idx_rst = 1'b1;
      end
      qec_pkg::MODE_X2_MAX: begin
        r.enc_en = 1'b1;
        r.max_rst = 1'b1;
      end
      qec_pkg::MODE_X2_IDX: begin
        r.enc_en = 1'b1;
        r.idx_rst = 1'b1;
      end
      qec_pkg::MODE_TIMER: begin
        r.timer_en = 1'b1;
      end
      qec_pkg::MODE_UNUSED3, qec_pkg::MODE_UNUSED2, qec_pkg::MODE_OFF: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // register index match, shared by the write decodes
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] idx);
    return a == idx;
  endfunction

  // control word as software sees it: flag, status bits and stored fields
  function automatic logic [15:0] ctrl_view(input logic [15:0] c, input logic err, input logic idx,
                                            input logic dir);
    logic [15:0] v;
    v = c & qec_pkg::CTRL_WMASK;
    v[qec_pkg::BIT_CNT_ERR] = err;
    v[qec_pkg::BIT_INDEX] = idx;
    v[qec_pkg::BIT_DIR] = dir;
    return v;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [15:0] ctrl_q;
  logic [15:0] pos_q;
  logic [15:0] max_q;
  logic cnt_err_q;
  logic dir_q;
  logic idx_q;
  logic [2:0] mode;
  qec_pkg::qec_mode_s md;
  logic run;
  logic cnt_pulse;
  logic cnt_up;
  logic idx_rise;
  logic max_hit;
  logic min_hit;
  logic wr_ctrl;
  logic wr_pos;
  logic wr_max;
  logic err_event;
  logic tmr_step;
  logic ph_a;
  logic ph_b;
  logic dec_run;
  logic idx_clear;
  logic [15:0] pos_d;
  logic [15:0] ctrl_d;

  assign mode = ctrl_q[qec_pkg::BIT_MODE_HI:qec_pkg::BIT_MODE_LO];
  assign md = mode_decode(mode);
  // chip idle with stop bit set halts the decoder, index clear and timer
  assign run = ~(i_idle & ctrl_q[qec_pkg::BIT_IDLE_STOP]);

  // ****************************************
  // address decode
  // ****************************************
  // one-cycle write strobes per register
  assign wr_ctrl = i_wr & addr_hit(i_addr, qec_pkg::ADDR_CTRL);
  assign wr_pos = i_wr & addr_hit(i_addr, qec_pkg::ADDR_POS);
  assign wr_max = i_wr & addr_hit(i_addr, qec_pkg::ADDR_MAX);

  // optional phase swap ahead of the decoder
  assign ph_a = ctrl_q[qec_pkg::BIT_SWAP] ? i_phase_b : i_phase_a;
  assign ph_b = ctrl_q[qec_pkg::BIT_SWAP] ? i_phase_a : i_phase_b;
  // decoder and index clear both stop in idle when asked to
  assign dec_run = run & md.enc_en;
  assign idx_clear = run & md.idx_rst & idx_rise;

  // ****************************************
  // phase decoder
  // ****************************************
  qec_quad_decoder u_dec (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(dec_run),
    .i_x4(md.x4),
    .i_phase_a(ph_a),
    .i_phase_b(ph_b),
    .o_count(cnt_pulse),
    .o_up(cnt_up)
  );

  // ****************************************
  // index and limit detection
  // ****************************************
  // index edge history
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      idx_q <= 1'b0;
    end else begin
      idx_q <= i_index;
    end
  end

  assign idx_rise = i_index & ~idx_q;
  assign max_hit = (pos_q == max_q);
  assign min_hit = (pos_q == 16'h0000);
  // counter hits a limit before the index pulse arrived
  assign err_event = cnt_pulse & md.idx_rst & ~idx_rise &
                     ((cnt_up & max_hit) | (~cnt_up & min_hit));
  assign tmr_step = run & md.timer_en & i_timer_tick &
                    (~ctrl_q[qec_pkg::BIT_GATE] | i_timer_gate);

  // ****************************************
  // control register
  // ****************************************
  // control next value: only the stored fields take a write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = i_wdata & qec_pkg::CTRL_WMASK;
    end
  end

  // control register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_q <= qec_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // count error flag: hardware set beats software clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_err_q <= 1'b0;
    end else if (err_event) begin
      cnt_err_q <= 1'b1;
    end else if (wr_ctrl) begin
      cnt_err_q <= i_wdata[qec_pkg::BIT_CNT_ERR];
    end
  end

  // direction: decoder driven in encoder modes, software driven otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dir_q <= 1'b0;
    end else if (md.enc_en) begin
      if (cnt_pulse) begin
        dir_q <= cnt_up; // source select ignored here
      end
    end else if (wr_ctrl) begin
      dir_q <= i_wdata[qec_pkg::BIT_DIR];
    end
  end

  // ****************************************
  // position counter / timer
  // ****************************************
  // next position: software load, index clear, encoder step, timer step
  always_comb begin
    pos_d = pos_q;
    if (wr_pos) begin
      pos_d = i_wdata;
    end else if (idx_clear) begin
      pos_d = 16'h0000;
    end else if (cnt_pulse & cnt_up) begin
      if (md.max_rst & max_hit) begin
        pos_d = 16'h0000;
      end else begin
        pos_d = pos_q + 16'h0001;
      end
    end else if (cnt_pulse) begin
      if (md.max_rst & min_hit) begin
        pos_d = max_q; // down from zero reloads the maximum
      end else begin
        pos_d = pos_q - 16'h0001;
      end
    end else if (tmr_step) begin
      if (max_hit) begin
        pos_d = 16'h0000;
      end else begin
        pos_d = pos_q + 16'h0001;
      end
    end
  end

  // position register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pos_q <= qec_pkg::POS_RESET;
    end else begin
      pos_q <= pos_d;
    end
  end

  // maximum count register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      max_q <= qec_pkg::MAX_RESET;
    end else if (wr_max) begin
      max_q <= i_wdata;
    end
  end

  // ****************************************
  // read port and outputs
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        qec_pkg::ADDR_CTRL: begin
          o_rdata <= ctrl_view(ctrl_q, cnt_err_q, idx_q, dir_q);
        end
        qec_pkg::ADDR_POS: begin
          o_rdata <= pos_q;
        end
        qec_pkg::ADDR_MAX: begin
          o_rdata <= max_q;
        end
        default: begin
          o_rdata <= 16'h0000; // unmapped index reads zero
        end
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // direction pin drive
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dir <= 1'b0;
    end else begin
      o_dir <= dir_q;
    end
  end

  // direction pin enable, only while an encoder mode is selected
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dir_oe <= 1'b0;
    end else begin
      o_dir_oe <= ctrl_q[qec_pkg::BIT_DIR_OE] & md.enc_en;
    end
  end

endmodule // qec_core

// *** bench/qec_enc_model.sv ***
// behavioural rotary encoder with quadrature phases and index mark
`timescale 1ns/1ps
module qec_enc_model (
  input wire logic i_clk,
  input wire logic i_step,
  input wire logic i_up,
  input wire logic i_mark,
  output logic o_phase_a,
  output logic o_phase_b,
  output logic o_index
);
  logic [1:0] ang_q = 2'h0;
  // one quarter turn per step, phase a leads b when turning up
  always_ff @(posedge i_clk) begin
    if (i_step) begin
      ang_q <= i_up ? ang_q + 2'h1 : ang_q - 2'h1;
    end
  end
  // gray order 00,10,11,01
  assign o_phase_a = ang_q[1] ^ ang_q[0];
  assign o_phase_b = ang_q[1];
  assign o_index = i_mark;
endmodule // qec_enc_model

// *** bench/qec_core_props.sv ***
// assertions on the ports of the encoder control core
`timescale 1ns/1ps
module qec_core_props (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic i_idle,
  input wire logic o_dir,
  input wire logic o_dir_oe
);
  logic [15:0] ctl_q;
  logic [15:0] pl_q;
  logic [3:0] ad_q;
  logic rd_q;
  logic pv_q;
  logic fc_q;
  wire logic [2:0] md = ctl_q[10:8];
  wire logic run = md[2] && !ctl_q[7] && !(ctl_q[13] && i_idle);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // mirror of control writes; fc_q marks a flag clear in a max mode
  always_ff @(posedge i_core_clk) begin
    rd_q <= i_rd;
    ad_q <= i_addr;
    if (i_rst) begin
      ctl_q <= 16'h0000;
      fc_q <= 1'b0;
    end else if (i_wr && i_addr == 4'h0) begin
      ctl_q <= i_wdata;
      fc_q <= !i_wdata[15] && i_wdata[10] && i_wdata[8];
    end
  end
  // last position read, and whether the counter should be frozen since
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_wr) begin
      pv_q <= 1'b0;
    end else if (rd_q && ad_q == 4'h1) begin
      pv_q <= !md[2] && md != 3'h1;
      pl_q <= o_rdata;
    end
  end
  chk_oe_on: assert property (
    $stable(ctl_q) && $past($stable(ctl_q)) && md[2] && ctl_q[6] |-> o_dir_oe) else $error("oe low");
  chk_oe_off: assert property (
    $stable(ctl_q) && $past($stable(ctl_q)) && !md[2] |-> !o_dir_oe) else $error("oe high");
  chk_ctl_rdbk: assert property (
    $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata[13] == $past(ctl_q[13]) && o_rdata[10:8] == $past(md))
    else $error("control readback");
  chk_flag_max: assert property (
    $past(i_rd) && $past(i_addr) == 4'h0 && $past(fc_q) |-> !o_rdata[15]) else $error("flag in max mode");
  chk_dir_up: assert property (
    run && $rose(i_phase_a) && !i_phase_b |-> ##[1:4] o_dir) else $error("dir not up");
  chk_dir_down: assert property (
    run && $rose(i_phase_a) && i_phase_b |-> ##[1:4] !o_dir) else $error("dir not down");
  chk_idle_hold: assert property (
    md[2] && ctl_q[13] && $past(ctl_q[13], 2) && i_idle && $past(i_idle) && $past(i_idle, 2) |-> $stable(o_dir))
    else $error("moved in idle");
  chk_pos_hold: assert property (
    rd_q && ad_q == 4'h1 && pv_q |-> o_rdata == pl_q) else $error("position moved while off");
endmodule // qec_core_props
bind qec_core qec_core_props i_props (.*);

// *** bench/qec_core_tb_top.sv ***
// self-checking bench for the encoder control core
`timescale 1ns/1ps
module qec_core_tb_top;
  typedef struct {logic [15:0] ctl; logic up; logic [15:0] dlt;} qec_row_s;
  qec_row_s rows [8] = '{'{16'h0741, 1'b1, 16'h0008}, '{16'h0540, 1'b1, 16'h0004},
    '{16'h0441, 1'b1, 16'h0004}, '{16'h0640, 1'b0, 16'hFFF8}, '{16'h0340, 1'b1, 16'h0000},
    '{16'h0240, 1'b1, 16'h0000}, '{16'h0040, 1'b1, 16'h0000}, '{16'h0100, 1'b0, 16'h0000}};
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_idle = 1'b0;
  logic i_timer_tick = 1'b0, i_timer_gate = 1'b0, step = 1'b0, up = 1'b0, mark = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata, p0, p1;
  logic i_phase_a, i_phase_b, i_index, o_dir, o_dir_oe;
  int n_errors = 0, compares = 0;
  qec_core i_dut (.*);
  qec_enc_model i_enc (.i_clk(i_core_clk), .i_step(step), .i_up(up), .i_mark(mark),
    .o_phase_a(i_phase_a), .o_phase_b(i_phase_b), .o_index(i_index));
  // 50 ns clock
  initial forever #25 i_core_clk = ~i_core_clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
    rd(a, p1);
    chk(nm, e, p1);
  endtask
  // n quarter turns, eight clocks apart
  task automatic mv(input int n, input logic u);
    repeat (n) begin
      @(posedge i_core_clk);
      step <= 1'b1;
      up <= u;
      @(posedge i_core_clk);
      step <= 1'b0;
      repeat (6) @(posedge i_core_clk);
    end
  endtask
  task automatic pm;
    @(posedge i_core_clk);
    mark <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    mark <= 1'b0;
  endtask
  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_errors++;
    results;
  end
  // mode table, then reset and awkward cases
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    foreach (rows[k]) begin
      wr(4'h0, rows[k].ctl);
      rd(4'h1, p0);
      mv(8, rows[k].up);
      rd(4'h1, p1);
      chk("position step", rows[k].dlt, p1 - p0);
      if (rows[k].ctl[10]) chk("direction", {15'h0000, rows[k].up}, {15'h0000, o_dir});
      chk("dir enable", {15'h0000, rows[k].ctl[6] & rows[k].ctl[10]}, {15'h0000, o_dir_oe});
      $display("row %0d done", k);
    end
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rc(4'h0, 16'h0000, "control reset");
    rc(4'h1, 16'h0000, "position reset");
    rc(4'h2, 16'hFFFF, "max reset");
    rc(4'hF, 16'h0000, "unmapped read");
    $display("reset test done");
    wr(4'h2, 16'h0003);
    wr(4'h0, 16'h0700);
    mv(5, 1'b1);
    rc(4'h1, 16'h0001, "wrap up");
    mv(2, 1'b0);
    rc(4'h1, 16'h0003, "wrap down");
    $display("wrap test done");
    wr(4'h2, 16'hFFFF);
    wr(4'h0, 16'h0600);
    mv(4, 1'b0);
    rc(4'h0, 16'h8600, "count error");
    pm;
    rc(4'h1, 16'h0000, "index x4");
    wr(4'h0, 16'h0500);
    mv(2, 1'b0);
    rc(4'h0, 16'h0500, "flag cleared");
    rc(4'h1, 16'hFFFF, "x2 down");
    wr(4'h0, 16'h0400);
    pm;
    rc(4'h1, 16'h0000, "index x2");
    $display("index test done");
    wr(4'h0, 16'h0100);
    repeat (5) begin
      @(posedge i_core_clk);
      i_timer_tick <= 1'b1;
      @(posedge i_core_clk);
      i_timer_tick <= 1'b0;
    end
    rc(4'h1, 16'h0005, "timer");
    wr(4'h0, 16'h2700);
    @(posedge i_core_clk);
    i_idle <= 1'b1;
    mv(4, 1'b1);
    rc(4'h1, 16'h0005, "idle stopped");
    wr(4'h0, 16'h0700);
    mv(4, 1'b1);
    rc(4'h1, 16'h0009, "idle running");
    $display("timer and idle test done");
    results;
  end
endmodule // qec_core_tb_top
